// ### hw/rtbp_edge_sync.v
`timescale 1ns/10ps

module rtbp_edge_sync
(
    input  wire core_clk,   // System clock
    input  wire rst_n,      // Synchronous reset, active low
    input  wire ce,         // Clock enable
    input  wire pin_i,      // Asynchronous pin
    output wire fall        // One-cycle pulse on a falling edge
);

    reg meta_q;
    reg sync_q;
    reg last_q;

    // The first stage feeds only the second one
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            last_q <= 1'b1;
        end
        else if (ce)
        begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    assign fall = ce & last_q & ~sync_q;

endmodule // rtbp_edge_sync

// ### hw/rtbp_prescaler.v
`timescale 1ns/10ps
`include "rtbp_regs.vh"

module rtbp_prescaler
(
    input  wire       core_clk,   // System clock
    input  wire       rst_n,      // Synchronous reset, active low
    input  wire       ce,         // Clock enable
    input  wire       run,        // Count while high
    input  wire [2:0] rate_sel,   // Divider code
    output wire       tick        // One-cycle step pulse
);

    reg  [7:0] div_q;
    reg  [7:0] mask;

    // Code 0 divides by 256, each step halves the divisor
    always @*
    begin
        mask = 8'hff >> rate_sel;
    end

    always @(posedge core_clk)
    begin
        if (!rst_n)
            div_q <= 8'h00;
        else if (ce)
        begin
            if (run)
                div_q <= div_q + 8'h01;
            else
                div_q <= 8'h00;
        end
    end

    assign tick = ce & run & ((div_q & mask) == mask);

endmodule // rtbp_prescaler

// ### hw/rtbp_regs.vh
`ifndef RTBP_REGS_VH
`define RTBP_REGS_VH

// Register offsets
`define RTBP_MODE_ADDR     8'h88
`define RTBP_COUNT_ADDR    8'h89
`define RTBP_RELOAD_ADDR   8'h8a
`define RTBP_IRQ_ADDR      8'h8b

// Mode register fields
`define RTBP_PWM_EN_BIT    0
`define RTBP_TOGGLE_BIT    1
`define RTBP_ALOAD_BIT     2
`define RTBP_CKS_BIT       3
`define RTBP_RATE_LSB      4
`define RTBP_RATE_MSB      6
`define RTBP_RUN_BIT       7

// Interrupt register fields
`define RTBP_IRQ_FLAG_BIT  0
`define RTBP_IRQ_EN_BIT    1

// Reset values
`define RTBP_MODE_RST      8'h00
`define RTBP_COUNT_RST     8'h00
`define RTBP_RELOAD_RST    8'h00

// Overflow boundary masks (modulus minus one)
`define RTBP_MASK_256      8'hff
`define RTBP_MASK_64       8'h3f
`define RTBP_MASK_32       8'h1f
`define RTBP_MASK_16       8'h0f

`endif

// ### hw/rtbp_timer.v
// How it works
// - With auto-reload and PWM off, overflow copies the reload value into the count.
// - Reload writes go to a holding buffer, made active at next overflow.
// - PWM on: reload transfer every overflow; select bits set the boundary.
// - Reload register is 8-bit, write-only, cleared at reset.
// - PWM modulus 256/64/32/16 from select bits on internal clock; otherwise 256.
// - Toggle output inverts on every overflow.
// - Toggle enabled drives the shared pin and disables its GPIO.
// - PWM high while count below reload, low otherwise.
// - Counter wrap to zero in PWM mode starts the output high.
// - Duty is reload over modulus; zero reload holds output low.
// - Duty written mid-period takes effect from the next period.
// - PWM enabled drives the shared pin and disables its GPIO.
// - Overflow request keeps working in PWM, once per period.
// - Clearing run stops counting, toggle and PWM outputs.
// - Prescaler code sits in mode bits 4 to 6, internal clock only.
// - Codes 000..111 divide the clock by 256 down to 2.
// - External source counts event pin falling edges, no prescaler.
`timescale 1ns/10ps
`include "rtbp_regs.vh"

module rtbp_timer
(
    input  wire       core_clk,      // System clock, 100 MHz
    input  wire       rst_n,         // Synchronous reset, active low
    input  wire       ce,            // Clock enable, freezes all state
    input  wire [7:0] reg_addr,      // Register address
    input  wire [7:0] reg_wdata,     // Write data
    input  wire       reg_wr,        // Write strobe
    input  wire       reg_rd,        // Read strobe
    output reg  [7:0] reg_rdata,     // Read data, cycle after strobe
    input  wire       event_pin,     // External event input pin
    output wire       wave_out_pin,  // Timer waveform to shared pin
    output wire       gpio_disable,  // High while timer owns the pin
    output wire       overflow_irq   // Gated overflow request
);

    reg  [7:0] mode_q;
    reg  [7:0] count_q;
    reg  [7:0] count_d;
    reg  [7:0] hold_q;
    reg  [7:0] active_q;
    reg  [7:0] active_d;
    reg        toggle_q;
    reg        pwm_q;
    reg        pwm_d;
    reg        flag_q;
    reg        ien_q;
    reg  [7:0] mask;

    wire       pwm_en;
    wire       toggle_sel;
    wire       aload_sel;
    wire       ext_sel;
    wire       run;
    wire [2:0] rate_sel;
    wire       presc_tick;
    wire       ext_fall;
    wire       step;
    wire       ovf;
    wire       wr_mode;
    wire       wr_count;
    wire       wr_reload;
    wire       wr_irq;

    assign pwm_en     = mode_q[`RTBP_PWM_EN_BIT];
    assign toggle_sel = mode_q[`RTBP_TOGGLE_BIT];
    assign aload_sel  = mode_q[`RTBP_ALOAD_BIT];
    assign ext_sel    = mode_q[`RTBP_CKS_BIT];
    assign run        = mode_q[`RTBP_RUN_BIT];
    assign rate_sel   = mode_q[`RTBP_RATE_MSB:`RTBP_RATE_LSB];

    assign wr_mode    = reg_wr & (reg_addr == `RTBP_MODE_ADDR);
    assign wr_count   = reg_wr & (reg_addr == `RTBP_COUNT_ADDR);
    assign wr_reload  = reg_wr & (reg_addr == `RTBP_RELOAD_ADDR);
    assign wr_irq     = reg_wr & (reg_addr == `RTBP_IRQ_ADDR);

    // Prescaler only runs on the internal source
    rtbp_prescaler u_presc
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .run      (run & ~ext_sel),
        .rate_sel (rate_sel),
        .tick     (presc_tick)
    );

    rtbp_edge_sync u_event
    (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .pin_i    (event_pin),
        .fall     (ext_fall)
    );

    // Event edges are dropped while the timer is stopped
    assign step = run & (ext_sel ? ext_fall : presc_tick);

    // Reduced modulus applies only to PWM on the internal source
    always @*
    begin
        mask = `RTBP_MASK_256;
        if (pwm_en && !ext_sel)
        begin
            case ({aload_sel, toggle_sel})
                2'b00:   mask = `RTBP_MASK_256;
                2'b01:   mask = `RTBP_MASK_64;
                2'b10:   mask = `RTBP_MASK_32;
                2'b11:   mask = `RTBP_MASK_16;
                default: mask = `RTBP_MASK_256;
            endcase
        end
    end

    assign ovf = step & ((count_q & mask) == mask);

    // Next count and active reload value
    always @*
    begin
        count_d  = count_q;
        active_d = active_q;
        if (ovf)
        begin
            active_d = hold_q;
            if (pwm_en)
                count_d = 8'h00;
            else if (aload_sel)
                count_d = hold_q;
            else
                count_d = 8'h00;
        end
        else if (step)
        begin
            count_d = count_q + 8'h01;
        end
        // A software count write wins over a step in the same cycle
        if (wr_count)
            count_d = reg_wdata;
    end

    // Registered compare keeps the pin glitch free
    always @*
    begin
        pwm_d = 1'b0;
        if (run && pwm_en)
            pwm_d = (count_d & mask) < (active_d & mask);
    end

    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            mode_q   <= `RTBP_MODE_RST;
            count_q  <= `RTBP_COUNT_RST;
            hold_q   <= `RTBP_RELOAD_RST;
            active_q <= `RTBP_RELOAD_RST;
            toggle_q <= 1'b0;
            pwm_q    <= 1'b0;
            flag_q   <= 1'b0;
            ien_q    <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_mode)
                mode_q <= reg_wdata;
            count_q  <= count_d;
            active_q <= active_d;
            if (wr_reload)
                hold_q <= reg_wdata;
            if (ovf)
                toggle_q <= ~toggle_q;
            pwm_q <= pwm_d;
            // Set wins over a clear in the same cycle
            if (wr_irq)
            begin
                flag_q <= ovf | (flag_q & reg_wdata[`RTBP_IRQ_FLAG_BIT]);
                ien_q  <= reg_wdata[`RTBP_IRQ_EN_BIT];
            end
            else if (ovf)
                flag_q <= 1'b1;
        end
    end

    // Reload register reads as zero; it is write-only
    always @(posedge core_clk)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else if (ce)
        begin
            reg_rdata <= 8'h00;
            if (reg_rd)
            begin
                case (reg_addr)
                    `RTBP_MODE_ADDR:   reg_rdata <= mode_q;
                    `RTBP_COUNT_ADDR:  reg_rdata <= count_q;
                    `RTBP_RELOAD_ADDR: reg_rdata <= 8'h00;
                    `RTBP_IRQ_ADDR:    reg_rdata <= {6'b00_0000, ien_q,
                                                     flag_q};
                    default:           reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Stopped timer holds the toggle level and drives PWM low
    assign gpio_disable = pwm_en | toggle_sel;
    assign wave_out_pin = pwm_en ? pwm_q : toggle_q;
    assign overflow_irq = flag_q & ien_q;

endmodule // rtbp_timer

// ### verification/rtbp_timer_checker.sv
`timescale 1ns/10ps
`include "rtbp_regs.vh"

module rtbp_timer_checker
(
    input wire       core_clk,     // Clock
    input wire       rst_n,        // Reset
    input wire       ce,           // Enable
    input wire [7:0] reg_addr,     // Address
    input wire [7:0] reg_wdata,    // Write data
    input wire       reg_wr,       // Write
    input wire       reg_rd,       // Read
    input wire [7:0] reg_rdata,    // Read data
    input wire       event_pin,    // Event
    input wire       wave_out_pin, // Wave
    input wire       gpio_disable, // Pin owned
    input wire       overflow_irq  // Request
);
    reg  [7:0] mode_q;
    reg        irq_en_q;
    wire       wr_ok = ce && reg_wr;
    wire       plain = !mode_q[0] && irq_en_q;

    // Shadow copies, since only the ports are visible here
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            mode_q   <= 8'h00;
            irq_en_q <= 1'b0;
        end
        else if (wr_ok && reg_addr == `RTBP_MODE_ADDR)
            mode_q <= reg_wdata;
        else if (wr_ok && reg_addr == `RTBP_IRQ_ADDR)
            irq_en_q <= reg_wdata[1];
    end

    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    reload_rd_zero_a: assert property (
        $past(ce) && $past(reg_rd) && $past(reg_addr) == `RTBP_RELOAD_ADDR
        |-> reg_rdata == 8'h00) else $error("reload read not zero");
    pin_owner_a: assert property (
        gpio_disable == (mode_q[0] | mode_q[1]))
        else $error("pin ownership wrong");
    irq_gate_a: assert property (
        overflow_irq |-> irq_en_q) else $error("request while disabled");
    irq_sticky_a: assert property (
        overflow_irq && !(wr_ok && reg_addr == `RTBP_IRQ_ADDR)
        |=> overflow_irq) else $error("flag dropped by itself");
    irq_cause_a: assert property (
        $rose(overflow_irq) |-> $past(mode_q[7]) || $rose(irq_en_q))
        else $error("flag set while stopped");
    pwm_stop_a: assert property (
        ce && mode_q[0] && !mode_q[7] |=> !mode_q[0] || !wave_out_pin)
        else $error("pwm output runs while stopped");
    toggle_hold_a: assert property (
        !mode_q[0] && !mode_q[7] |=> mode_q[0] || $stable(wave_out_pin))
        else $error("toggle moved while stopped");
    toggle_flag_a: assert property (
        $changed(wave_out_pin) && plain && $past(plain)
        && !$past(overflow_irq) |-> overflow_irq)
        else $error("toggle without overflow");
endmodule // rtbp_timer_checker

// ### verification/rtbp_timer_test.sv
`timescale 1ns/10ps
`include "rtbp_regs.vh"

module rtbp_timer_test;
    reg        core_clk  = 1'b0;
    reg        rst_n     = 1'b0;
    reg  [7:0] reg_addr  = 8'h00;
    reg  [7:0] reg_wdata = 8'h00;
    reg        reg_wr    = 1'b0;
    reg        reg_rd    = 1'b0;
    reg        event_pin = 1'b1;
    reg        ce        = 1'b1;
    wire [7:0] reg_rdata;
    wire       wave_out_pin;
    wire       gpio_disable;
    wire       overflow_irq;
    integer    n_fail = 0;
    integer    total_checks = 0;
    integer    i;
    integer    hi;
    reg [23:0] rows [0:4]; // Address, write data, read-back

    always #5 core_clk = ~core_clk;

    rtbp_timer dut_u
    (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .ce           (ce),
        .reg_addr     (reg_addr),
        .reg_wdata    (reg_wdata),
        .reg_wr       (reg_wr),
        .reg_rd       (reg_rd),
        .reg_rdata    (reg_rdata),
        .event_pin    (event_pin),
        .wave_out_pin (wave_out_pin),
        .gpio_disable (gpio_disable),
        .overflow_irq (overflow_irq)
    );

    task chk8(input [7:0] got, input [7:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    end
    endtask

    task chk1(input got, input exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask

    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        @(negedge core_clk);
    end
    endtask

    task rd(input [7:0] a, input [7:0] exp);
    begin
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(negedge core_clk);
        chk8(reg_rdata, exp);
    end
    endtask

    // Bounded, so a dead timer ends the run instead of hanging it
    task wait_irq;
        integer k;
    begin
        k = 0;
        while (overflow_irq !== 1'b1 && k < 600)
        begin
            @(negedge core_clk);
            k = k + 1;
        end
        if (k == 600)
        begin
            chk1(1'b0, 1'b1);
            tally_and_finish;
        end
    end
    endtask

    task count_high(input integer n);
    begin
        hi = 0;
        repeat (n)
        begin
            @(negedge core_clk);
            hi = hi + (wave_out_pin === 1'b1);
        end
    end
    endtask

    task tally_and_finish;
    begin
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
    endtask

    initial
    begin
        rows[0] = 24'h88_0606;
        rows[1] = 24'h89_5a5a;
        rows[2] = 24'h8a_a500;
        rows[3] = 24'h8c_ff00;
        rows[4] = 24'h8b_0202;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i = i + 1)
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        chk1(gpio_disable, 1'b1);
        $display("register table done");
        wr(`RTBP_RELOAD_ADDR, 8'h10);
        wr(`RTBP_COUNT_ADDR, 8'hff);
        wr(`RTBP_MODE_ADDR, 8'h86);
        wait_irq;
        wr(`RTBP_MODE_ADDR, 8'h06);
        rd(`RTBP_COUNT_ADDR, 8'h10);
        chk1(wave_out_pin, 1'b1);
        wr(`RTBP_IRQ_ADDR, 8'h02);
        chk1(overflow_irq, 1'b0);
        $display("reload and toggle done");
        // Modulus 16, divide by 2: one period is 32 clocks
        wr(`RTBP_RELOAD_ADDR, 8'h04);
        wr(`RTBP_COUNT_ADDR, 8'h0f);
        wr(`RTBP_MODE_ADDR, 8'hf7);
        wait_irq;
        count_high(32);
        chk8(hi[7:0], 8'h08);
        wr(`RTBP_IRQ_ADDR, 8'h02);
        wait_irq;
        wr(`RTBP_RELOAD_ADDR, 8'h00);
        chk1(wave_out_pin, 1'b1);
        wr(`RTBP_MODE_ADDR, 8'h77);
        @(negedge core_clk);
        chk1(wave_out_pin, 1'b0);
        wr(`RTBP_IRQ_ADDR, 8'h02);
        wr(`RTBP_MODE_ADDR, 8'hf7);
        wait_irq;
        count_high(32);
        chk8(hi[7:0], 8'h00);
        $display("pwm done");
        // Stop first, or a live step lands on the count write
        wr(`RTBP_MODE_ADDR, 8'h08);
        wr(`RTBP_IRQ_ADDR, 8'h02);
        wr(`RTBP_COUNT_ADDR, 8'hfe);
        wr(`RTBP_MODE_ADDR, 8'h88);
        repeat (2)
        begin
            @(posedge core_clk);
            event_pin <= 1'b0;
            repeat (4) @(posedge core_clk);
            event_pin <= 1'b1;
            repeat (4) @(posedge core_clk);
        end
        rd(`RTBP_COUNT_ADDR, 8'h00);
        chk1(overflow_irq, 1'b1);
        chk1(gpio_disable, 1'b0);
        // A pulse seen only while the enable is low must not count
        @(posedge core_clk);
        ce        <= 1'b0;
        event_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        event_pin <= 1'b1;
        repeat (4) @(posedge core_clk);
        ce        <= 1'b1;
        rd(`RTBP_COUNT_ADDR, 8'h00);
        $display("event count done");
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`RTBP_MODE_ADDR, 8'h00);
        rd(`RTBP_IRQ_ADDR, 8'h00);
        chk1(wave_out_pin, 1'b0);
        $display("reset done");
        tally_and_finish;
    end
endmodule // rtbp_timer_test

bind rtbp_timer rtbp_timer_checker chk_u
(
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .ce           (ce),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .event_pin    (event_pin),
    .wave_out_pin (wave_out_pin),
    .gpio_disable (gpio_disable),
    .overflow_irq (overflow_irq)
);
